// >>> epl_bits.sv
`timescale 1ns/1ps
`include "epl_consts.svh"
module epl_bits (
  input wire logic clk,
  input wire logic rstn,
  input wire epl_pkg::epl_edge_req_t edge_req,
  input wire epl_pkg::epl_latch_req_t latch_req,
  input wire logic retain_en,
  input wire logic [15:0] latch_preset,
  output logic [15:0] pulse_bits,
  output logic latch_bit
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  epl_pkg::epl_state_t state_reg;
  epl_pkg::epl_state_t state_next;

  // edge decision shared by both kinds
  function automatic logic epl_edge(input epl_pkg::epl_kind_t kind,
                                    input logic prev, input logic cur);
    if (kind == epl_pkg::EPL_RISING) begin
      epl_edge = !prev && cur;
    end else begin
      epl_edge = prev && !cur;
    end
  endfunction

  // next state; this block has no flag outputs at all
  always_comb begin
    state_next = state_reg;
    // index width caps instances at sixteen
    if (edge_req.exec && !edge_req.interlocked) begin
      state_next.pulse[edge_req.idx] =
        epl_edge(edge_req.kind, state_reg.prev[edge_req.idx],
                 edge_req.cond);
      state_next.prev[edge_req.idx] = edge_req.cond;
    end
    // interlocked: nothing recorded, pulse untouched
    if (latch_req.exec && !latch_req.interlocked) begin
      if (latch_req.rst_cond) begin
        state_next.latch = 1'b0;
      end else if (latch_req.set_cond) begin
        state_next.latch = 1'b1;
      end
    end
    // interlock leaves latch alone
    // retained latch takes its saved value once after each reset
    if (!state_reg.latch_valid) begin
      state_next.latch_valid = 1'b1;
      if (retain_en) begin
        state_next.latch = latch_preset[0];
      end
    end
  end

  // single register stage; reset only loads constants
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.prev <= `EPL_PREV_RST;
      state_reg.pulse <= `EPL_PULSE_RST;
      state_reg.latch <= `EPL_LATCH_RST;
      state_reg.latch_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulse_bits = state_reg.pulse;
  assign latch_bit = state_reg.latch;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  rise_pulse_on_a: assert property (
    edge_req.exec && !edge_req.interlocked &&
    edge_req.kind == epl_pkg::EPL_RISING && edge_req.cond &&
    !state_reg.prev[edge_req.idx] |=> pulse_bits[$past(edge_req.idx)])
    else $error("rising pulse missing");
  rise_pulse_off_a: assert property (
    edge_req.exec && !edge_req.interlocked &&
    edge_req.kind == epl_pkg::EPL_RISING &&
    state_reg.prev[edge_req.idx] |=> !pulse_bits[$past(edge_req.idx)])
    else $error("rising pulse too long");
  fall_pulse_on_a: assert property (
    edge_req.exec && !edge_req.interlocked &&
    edge_req.kind == epl_pkg::EPL_FALLING && !edge_req.cond &&
    state_reg.prev[edge_req.idx] |=> pulse_bits[$past(edge_req.idx)])
    else $error("falling pulse missing");
  fall_pulse_off_a: assert property (
    edge_req.exec && !edge_req.interlocked &&
    edge_req.kind == epl_pkg::EPL_FALLING &&
    !state_reg.prev[edge_req.idx] |=> !pulse_bits[$past(edge_req.idx)])
    else $error("falling pulse without edge");
  prev_update_a: assert property (
    edge_req.exec && !edge_req.interlocked |=>
    state_reg.prev[$past(edge_req.idx)] == $past(edge_req.cond))
    else $error("previous condition not stored");
  prev_frozen_a: assert property (
    edge_req.exec && edge_req.interlocked && state_reg.latch_valid |=>
    $stable(state_reg.prev) && $stable(pulse_bits))
    else $error("interlocked instance changed");
  latch_set_a: assert property (
    state_reg.latch_valid && latch_req.exec && !latch_req.interlocked &&
    latch_req.set_cond && !latch_req.rst_cond |=> latch_bit)
    else $error("latch not set");
  latch_rst_a: assert property (
    state_reg.latch_valid && latch_req.exec && !latch_req.interlocked &&
    latch_req.rst_cond |=> !latch_bit)
    else $error("latch not reset");
  latch_hold_a: assert property (
    state_reg.latch_valid &&
    (!latch_req.exec || latch_req.interlocked) |=> $stable(latch_bit))
    else $error("latch changed while idle");
  latch_both_a: assert property (
    state_reg.latch_valid && latch_req.exec && !latch_req.interlocked &&
    latch_req.set_cond && latch_req.rst_cond |=> !latch_bit)
    else $error("set beat reset");
  retain_load_a: assert property (
    !state_reg.latch_valid && retain_en |=>
    latch_bit == $past(latch_preset[0]))
    else $error("retained latch lost");
  pulse_isolate_a: assert property (
    edge_req.exec && !edge_req.interlocked |=>
    ((pulse_bits ^ $past(pulse_bits)) &
     ~(16'h0001 << $past(edge_req.idx))) == 16'h0000)
    else $error("other pulse bit changed");
  pulse_idle_a: assert property (
    !edge_req.exec |=> $stable(pulse_bits))
    else $error("pulse changed without execution");

  rise_cover_c: cover property (pulse_bits != 16'h0000);
  latch_set_cover_c: cover property ($rose(latch_bit));
  latch_clr_cover_c: cover property ($fell(latch_bit));
  ilk_cover_c: cover property (edge_req.exec && edge_req.interlocked);
endmodule

// >>> epl_bits_tb.sv
`timescale 1ns/1ps
module epl_bits_tb;
  logic clk;
  logic rstn = 1'b0;
  logic retain_en = 1'b0;
  logic [15:0] latch_preset = 16'h0000;
  logic [15:0] pulse_bits;
  logic latch_bit;
  epl_pkg::epl_edge_req_t edge_req;
  epl_pkg::epl_latch_req_t latch_req;
  int err_total = 0;
  int checks_done = 0;
  epl_seq i_epl_seq (.clk(clk), .edge_req(edge_req), .latch_req(latch_req));
  epl_bits i_epl_bits (.clk(clk), .rstn(rstn), .edge_req(edge_req),
    .latch_req(latch_req), .retain_en(retain_en),
    .latch_preset(latch_preset), .pulse_bits(pulse_bits),
    .latch_bit(latch_bit));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %b want %b", $time, g, e);
    end
  endtask
  // look one step later, once the answer has landed
  task automatic ep(input logic [3:0] i, input logic k, input logic c,
    input logic il, input logic e);
    i_epl_seq.edge_step(i, k, c, il);
    #1;
    chk(pulse_bits[i], e);
  endtask
  task automatic lp(input logic s, input logic r, input logic il,
    input logic e);
    i_epl_seq.latch_step(s, r, il);
    #1;
    chk(latch_bit, e);
  endtask
  // mid-run reset; two idle edges after release before any request
  task automatic restart(input logic ret, input logic [15:0] pre);
    @(posedge clk);
    rstn <= 1'b0;
    retain_en <= ret;
    latch_preset <= pre;
    @(posedge clk);
    #1;
    chk(|{pulse_bits, latch_bit}, 1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_edge;
    ep(4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    ep(4'h3, 1'b0, 1'b1, 1'b0, 1'b1);
    ep(4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    ep(4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    ep(4'hf, 1'b1, 1'b0, 1'b0, 1'b0);
    ep(4'hf, 1'b1, 1'b1, 1'b0, 1'b0);
    ep(4'hf, 1'b1, 1'b0, 1'b0, 1'b1);
    ep(4'h3, 1'b0, 1'b1, 1'b0, 1'b1);
    ep(4'h3, 1'b0, 1'b0, 1'b1, 1'b1);
    ep(4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    ep(4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    ep(4'h3, 1'b0, 1'b1, 1'b1, 1'b0);
    ep(4'h3, 1'b0, 1'b1, 1'b0, 1'b1);
    $display("edge test done");
  endtask
  task automatic t_latch;
    lp(1'b1, 1'b0, 1'b0, 1'b1);
    lp(1'b0, 1'b0, 1'b0, 1'b1);
    lp(1'b0, 1'b1, 1'b1, 1'b1);
    lp(1'b0, 1'b1, 1'b0, 1'b0);
    lp(1'b0, 1'b0, 1'b0, 1'b0);
    lp(1'b1, 1'b0, 1'b1, 1'b0);
    lp(1'b1, 1'b0, 1'b0, 1'b1);
    lp(1'b1, 1'b1, 1'b0, 1'b0);
    restart(1'b1, 16'h0001);
    chk(latch_bit, 1'b1);
    restart(1'b0, 16'h0001);
    chk(latch_bit, 1'b0);
    $display("latch test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_edge;
    t_latch;
    print_verdict;
  end
  // whole run is some 56 cycles
  initial begin
    #20000;
    err_total++;
    print_verdict;
  end
endmodule

// >>> epl_consts.svh
`ifndef EPL_CONSTS_SVH
`define EPL_CONSTS_SVH
// -----------------------------------------------------------------
// sizes and reset values
// -----------------------------------------------------------------
`define EPL_NUM_EDGE 16
`define EPL_EDGE_IDX_W 4
`define EPL_PREV_RST 16'h0000
`define EPL_PULSE_RST 16'h0000
`define EPL_LATCH_RST 1'h0
`endif

// >>> epl_pkg.sv
package epl_pkg;
  // -----------------------------------------------------------------
  // edge instance kind
  // -----------------------------------------------------------------
  typedef enum logic {
    EPL_RISING,
    EPL_FALLING
  } epl_kind_t;

  // one execution request for an edge pulse instance
  typedef struct packed {
    logic exec;
    logic [3:0] idx;
    epl_kind_t kind;
    logic cond;
    logic interlocked;
  } epl_edge_req_t;

  // one execution request for the latching bit
  typedef struct packed {
    logic exec;
    logic set_cond;
    logic rst_cond;
    logic interlocked;
  } epl_latch_req_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] pulse;
    logic latch;
    logic latch_valid;
  } epl_state_t;
endpackage

// >>> epl_seq.sv
`timescale 1ns/1ps
// scan sequencer stand-in: one request per scan step
module epl_seq (
  input wire logic clk,
  output epl_pkg::epl_edge_req_t edge_req,
  output epl_pkg::epl_latch_req_t latch_req
);
  initial begin
    edge_req = '0;
    latch_req = '0;
  end
  // one instance a step, each bit owned by one instance
  task automatic edge_step(input logic [3:0] i, input logic k,
    input logic c, input logic il);
    @(posedge clk);
    edge_req <= {1'b1, i, k, c, il};
    @(posedge clk);
    edge_req.exec <= 1'b0;
  endtask
  // latch request, same pacing
  task automatic latch_step(input logic s, input logic r, input logic il);
    @(posedge clk);
    latch_req <= {1'b1, s, r, il};
    @(posedge clk);
    latch_req.exec <= 1'b0;
  endtask
endmodule
